// ### src/codec_defines.svh
// register offsets, field positions, reset values and timing counts
`ifndef CODEC_DEFINES_SVH
`define CODEC_DEFINES_SVH

`define ADDR_INDEX      2'h0
`define ADDR_IDATA      2'h1
`define ADDR_STATUS     2'h2
`define ADDR_PIO        2'h3

`define IX_PLAY_FMT     5'h08
`define IX_IFACE_CFG    5'h09
`define IX_PIN_CTRL     5'h0a
`define IX_MODE_ID      5'h0c
`define IX_LOOPBACK     5'h0d
`define IX_PLAY_UPPER   5'h0e
`define IX_PLAY_LOWER   5'h0f
`define IX_ALT_EN1      5'h10
`define IX_TIMER_LOW    5'h14
`define IX_TIMER_HIGH   5'h15
`define IX_ALT_STATUS   5'h18
`define IX_CAP_FMT      5'h1c
`define IX_CAP_UPPER    5'h1e
`define IX_CAP_LOWER    5'h1f

`define BIT_SINGLE_CH   2
`define BIT_IRQ_PIN_EN  1
`define BIT_DAC_ZERO    6
`define BIT_EXT_MODE    6
`define BIT_LOOPBACK_EN 0
`define BIT_TIMER_EN    6
`define BIT_STEREO      4
`define BIT_PLAY_IRQ    4
`define BIT_CAP_IRQ     5
`define BIT_TIMER_IRQ   6
`define BIT_REQ_DISABLE 5
`define BIT_INT         0

`define INDEX_RESET     8'h40
`define CLK_PERIOD_NS   100
`define TIMER_TICK_NS   10000
`define TIMER_TICK_CYC  ((`TIMER_TICK_NS) / (`CLK_PERIOD_NS))

`endif

// ### src/codec_pkg.sv
// shared types of the codec control core
package codec_pkg;

    typedef struct packed {
        logic signed [15:0] left;
        logic signed [15:0] right;
    } stereo_sample_t;

    typedef struct packed {
        logic [1:0] addr;
        logic [7:0] data;
    } host_cycle_t;

endpackage : codec_pkg

// ### src/codec_count_timer_interrupt.sv
// counters, timer, interrupt, loopback mixing and register port
`timescale 1ns/1ps
`include "codec_defines.svh"

module codec_count_timer_interrupt #(
    parameter int TICK_CYC = `TIMER_TICK_CYC
) (
    input  wire logic                      clk_i,
    input  wire logic                      reset_n_i,
    input  wire logic                      cs_n_i,
    input  wire logic                      rd_n_i,
    input  wire logic                      wr_n_i,
    input  wire logic [1:0]                addr_i,
    input  wire logic [7:0]                data_i,
    output logic      [7:0]                data_o,
    output logic                           data_oe_o,
    output logic                           irq_o,
    input  wire logic                      sample_tick_i,
    input  wire codec_pkg::stereo_sample_t adc_i,
    input  wire codec_pkg::stereo_sample_t play_i,
    input  wire logic                      play_valid_i,
    input  wire logic                      play_xfer_i,
    input  wire logic                      cap_xfer_i,
    output codec_pkg::stereo_sample_t      dac_o,
    output codec_pkg::stereo_sample_t      cap_o,
    output logic                           play_drq_o,
    output logic                           cap_drq_o
);

    if (TICK_CYC < 1 || TICK_CYC > 65535) begin : g_tick_check
        $error("TICK_CYC out of range");
    end

    function automatic logic signed [15:0] sat16(
        input logic signed [16:0] s);
        if (s > 17'sd32767) begin
            sat16 = 16'sh7fff;
        end else if (s < -17'sd32768) begin
            sat16 = 16'sh8000;
        end else begin
            sat16 = s[15:0];
        end
    endfunction : sat16

    function automatic logic signed [15:0] mix(
        input logic signed [15:0] lb,
        input logic signed [15:0] bus);
        mix = sat16(17'(lb) + 17'(bus));
    endfunction : mix

    // ****************************************************************
    // host port synchronisers
    // ****************************************************************
    logic [2:0]             sync1_reg;
    logic [2:0]             sync2_reg;
    logic                   wr_n_d_reg;
    codec_pkg::host_cycle_t cyc1_reg;
    codec_pkg::host_cycle_t cyc2_reg;

    always_ff @(posedge clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            sync1_reg  <= 3'h7;
            sync2_reg  <= 3'h7;
            wr_n_d_reg <= 1'b1;
            cyc1_reg   <= '0;
            cyc2_reg   <= '0;
        end else begin
            sync1_reg  <= {cs_n_i, rd_n_i, wr_n_i};
            sync2_reg  <= sync1_reg;
            wr_n_d_reg <= sync2_reg[0];
            cyc1_reg   <= '{addr: addr_i, data: data_i};
            cyc2_reg   <= cyc1_reg;
        end
    end

    wire       wr_pulse = !sync2_reg[2] && !sync2_reg[0] && wr_n_d_reg;
    wire       rd_act   = !sync2_reg[2] && !sync2_reg[1];
    wire [7:0] wdata    = cyc2_reg.data;

    // ****************************************************************
    // direct and indirect registers
    // ****************************************************************
    logic [7:0]  index_reg;
    logic [7:0]  pio_reg;
    logic [7:0]  ind_mem [32];
    logic [2:0]  flags_reg;
    logic [15:0] play_cnt_reg;
    logic [15:0] cap_cnt_reg;
    logic [15:0] timer_cnt_reg;

    wire ext_mode   = ind_mem[`IX_MODE_ID][`BIT_EXT_MODE];
    wire single_ch  = ind_mem[`IX_IFACE_CFG][`BIT_SINGLE_CH];
    wire pin_en     = ind_mem[`IX_PIN_CTRL][`BIT_IRQ_PIN_EN];
    wire dac_zero   = ind_mem[`IX_PIN_CTRL][`BIT_DAC_ZERO];
    wire lb_en      = ind_mem[`IX_LOOPBACK][`BIT_LOOPBACK_EN];
    wire [3:0] lb_att = ind_mem[`IX_LOOPBACK][5:2];
    wire timer_en   = ind_mem[`IX_ALT_EN1][`BIT_TIMER_EN];
    wire cap_mono   = !ind_mem[`IX_CAP_FMT][`BIT_STEREO];
    wire play_st    = ind_mem[`IX_PLAY_FMT][`BIT_STEREO];
    wire transfer_request_disable = index_reg[`BIT_REQ_DISABLE];
    wire int_status = |flags_reg;
    wire cap_dedic  = ext_mode && !single_ch;

    // legacy mode ignores the upper index bit
    wire [4:0] ix = {ext_mode && index_reg[4], index_reg[3:0]};

    wire wr_index  = wr_pulse && cyc2_reg.addr == `ADDR_INDEX;
    wire wr_idata  = wr_pulse && cyc2_reg.addr == `ADDR_IDATA;
    wire wr_status = wr_pulse && cyc2_reg.addr == `ADDR_STATUS;
    wire wr_pio    = wr_pulse && cyc2_reg.addr == `ADDR_PIO;
    wire wr_flags  = wr_idata && ix == `IX_ALT_STATUS;

    always_ff @(posedge clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            index_reg <= `INDEX_RESET;
            pio_reg   <= 8'h00;
        end else begin
            if (wr_index) begin
                index_reg <= {1'b0, wdata[6:0]};
            end
            if (wr_pio) begin
                pio_reg <= wdata;
            end
        end
    end

    always_ff @(posedge clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            for (int i = 0; i < 32; i++) begin
                ind_mem[i] <= 8'h00;
            end
        end else if (wr_idata) begin
            ind_mem[ix] <= wdata;
        end
    end

    // ****************************************************************
    // DMA sample counters
    // ****************************************************************
    // without the dedicated pair, capture transfers count on playback
    wire play_cnt_en = play_xfer_i || (cap_xfer_i && !cap_dedic);
    wire cap_cnt_en  = cap_xfer_i && cap_dedic;
    wire play_evt    = play_cnt_en && play_cnt_reg == 16'h0000;
    wire cap_evt     = cap_cnt_en && cap_cnt_reg == 16'h0000;
    wire [15:0] play_base = {ind_mem[`IX_PLAY_UPPER],
                             ind_mem[`IX_PLAY_LOWER]};
    wire [15:0] cap_base  = {ind_mem[`IX_CAP_UPPER],
                             ind_mem[`IX_CAP_LOWER]};

    always_ff @(posedge clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            play_cnt_reg <= 16'h0000;
            cap_cnt_reg  <= 16'h0000;
        end else begin
            if (wr_idata && ix == `IX_PLAY_UPPER) begin
                play_cnt_reg <= {wdata, ind_mem[`IX_PLAY_LOWER]};
            end else if (play_evt) begin
                play_cnt_reg <= play_base;
            end else if (play_cnt_en) begin
                play_cnt_reg <= play_cnt_reg - 16'h0001;
            end
            if (wr_idata && ix == `IX_CAP_UPPER) begin
                cap_cnt_reg <= {wdata, ind_mem[`IX_CAP_LOWER]};
            end else if (cap_evt) begin
                cap_cnt_reg <= cap_base;
            end else if (cap_cnt_en) begin
                cap_cnt_reg <= cap_cnt_reg - 16'h0001;
            end
        end
    end

    // ****************************************************************
    // interval timer
    // ****************************************************************
    logic [15:0] tick_div_reg;
    wire         tick = tick_div_reg == 16'(TICK_CYC - 1);
    wire         timer_run = timer_en && tick;
    wire         timer_evt = timer_run && timer_cnt_reg == 16'h0001;
    wire [15:0]  timer_base = {ind_mem[`IX_TIMER_HIGH],
                               ind_mem[`IX_TIMER_LOW]};

    always_ff @(posedge clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            tick_div_reg  <= 16'h0000;
            timer_cnt_reg <= 16'h0000;
        end else begin
            tick_div_reg <= tick ? 16'h0000 : tick_div_reg + 16'h0001;
            if (wr_idata && ix == `IX_TIMER_LOW) begin
                timer_cnt_reg <= {ind_mem[`IX_TIMER_HIGH], wdata};
            end else if (timer_run && timer_cnt_reg == 16'h0000) begin
                timer_cnt_reg <= timer_base;
            end else if (timer_run) begin
                timer_cnt_reg <= timer_cnt_reg - 16'h0001;
            end
        end
    end

    // ****************************************************************
    // interrupt flags and pin
    // ****************************************************************
    logic [2:0] flags_clr;
    logic [2:0] flags_set;
    logic [2:0] flags_next;

    always_comb begin
        flags_clr = 3'h7;
        if (wr_status) begin
            flags_clr = 3'h0;
        end else if (wr_flags) begin
            flags_clr = {wdata[`BIT_TIMER_IRQ], wdata[`BIT_CAP_IRQ],
                         wdata[`BIT_PLAY_IRQ]};
        end
        flags_set  = {timer_evt, cap_evt && !single_ch, play_evt};
        flags_next = (flags_reg & flags_clr) | flags_set;
        flags_next[1] = flags_next[1] && !single_ch;
    end

    always_ff @(posedge clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            flags_reg <= 3'h0;
            irq_o     <= 1'b0;
        end else begin
            flags_reg <= flags_next;
            irq_o     <= (|flags_next) && pin_en;
        end
    end

    // ****************************************************************
    // loopback mixing, overrun and underrun
    // ****************************************************************
    codec_pkg::stereo_sample_t last_play_reg;
    logic                      cap_full_reg;

    wire signed [15:0] lb_l = lb_en ? adc_i.left >>> lb_att : 16'sh0000;
    wire signed [15:0] lb_r_raw = (cap_mono && play_st) ? adc_i.left
                                                        : adc_i.right;
    wire signed [15:0] lb_r = lb_en ? lb_r_raw >>> lb_att : 16'sh0000;
    wire codec_pkg::stereo_sample_t play_src =
        play_valid_i ? play_i
                     : (dac_zero ? '0 : last_play_reg);

    always_ff @(posedge clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            last_play_reg <= '0;
            dac_o         <= '0;
            cap_o         <= '0;
            cap_full_reg  <= 1'b0;
        end else begin
            if (sample_tick_i) begin
                last_play_reg <= play_src;
                dac_o.left    <= mix(lb_l, play_src.left);
                dac_o.right   <= mix(lb_r, play_src.right);
            end
            if (sample_tick_i && !cap_full_reg) begin
                cap_o        <= adc_i;
                cap_full_reg <= 1'b1;
            end else if (cap_xfer_i) begin
                cap_full_reg <= 1'b0;
            end
        end
    end

    // ****************************************************************
    // DMA requests and read port
    // ****************************************************************
    wire drq_gate = !(transfer_request_disable && int_status);
    assign play_drq_o = !play_valid_i && drq_gate;
    assign cap_drq_o  = cap_full_reg && drq_gate;

    wire [7:0] flags_byte = {1'b0, flags_reg[2], flags_reg[1],
                             flags_reg[0], 4'h0};
    wire [7:0] idata_rd = (ix == `IX_ALT_STATUS) ? flags_byte : ind_mem[ix];
    wire [7:0] status_rd = {7'h00, int_status};
    wire [7:0] rd_mux =
        (cyc2_reg.addr == `ADDR_INDEX)  ? index_reg :
        (cyc2_reg.addr == `ADDR_IDATA)  ? idata_rd  :
        (cyc2_reg.addr == `ADDR_STATUS) ? status_rd : pio_reg;

    always_ff @(posedge clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            data_o    <= 8'h00;
            data_oe_o <= 1'b0;
        end else begin
            data_o    <= rd_act ? rd_mux : 8'h00;
            data_oe_o <= rd_act;
        end
    end

endmodule : codec_count_timer_interrupt

// ### test/codec_count_timer_interrupt_checker.sv
// port assertions of the codec control core
`timescale 1ns/1ps
module codec_count_timer_interrupt_checker #(
    parameter int TICK_CYC = 100
) (
    input wire logic                      clk_i,
    input wire logic                      reset_n_i,
    input wire logic                      cs_n_i,
    input wire logic                      rd_n_i,
    input wire logic                      wr_n_i,
    input wire logic [1:0]                addr_i,
    input wire logic [7:0]                data_o,
    input wire logic                      data_oe_o,
    input wire logic                      irq_o,
    input wire logic                      sample_tick_i,
    input wire logic                      play_valid_i,
    input wire logic                      cap_xfer_i,
    input wire codec_pkg::stereo_sample_t dac_o,
    input wire codec_pkg::stereo_sample_t cap_o,
    input wire logic                      play_drq_o,
    input wire logic                      cap_drq_o
);
    default clocking @(posedge clk_i); endclocking
    default disable iff (!reset_n_i);

    chk_dac_tick_only: assert property (
        !sample_tick_i |=> $stable(dac_o)) else $error("dac moved");
    chk_cap_tick_only: assert property (
        !sample_tick_i && !cap_xfer_i |=> $stable(cap_o))
        else $error("capture moved");
    chk_cap_no_overwrite: assert property (
        cap_drq_o && !cap_xfer_i |=> $stable(cap_o))
        else $error("capture overwritten");
    chk_cap_drq_drop: assert property (
        cap_xfer_i && !sample_tick_i |=> !cap_drq_o)
        else $error("capture request stuck");
    chk_play_drq_valid: assert property (
        play_valid_i |-> !play_drq_o) else $error("playback request");
    chk_read_drive: assert property (
        (!cs_n_i && !rd_n_i) [*4] |=> data_oe_o)
        else $error("read not driven");
    chk_read_release: assert property (
        (cs_n_i || rd_n_i) [*5] |-> !data_oe_o)
        else $error("bus not released");
    chk_idle_data_zero: assert property (
        !data_oe_o |-> data_o == 8'h00) else $error("idle data");
    chk_status_clear: assert property (
        (!cs_n_i && !wr_n_i && addr_i == 2'h2) [*4] |=> !irq_o)
        else $error("status write kept irq");
    chk_irq_hold: assert property (
        (wr_n_i || cs_n_i) [*6] |=> !$fell(irq_o))
        else $error("irq fell without write");
endmodule : codec_count_timer_interrupt_checker

bind codec_count_timer_interrupt codec_count_timer_interrupt_checker #(
    .TICK_CYC(TICK_CYC)
) chk (.clk_i, .reset_n_i, .cs_n_i, .rd_n_i, .wr_n_i, .addr_i, .data_o,
    .data_oe_o, .irq_o, .sample_tick_i, .play_valid_i, .cap_xfer_i, .dac_o,
    .cap_o, .play_drq_o, .cap_drq_o);

// ### test/dma_host_model.sv
// isa dma controller answering the codec requests
`timescale 1ns/1ps
module dma_host_model (
    input  wire logic       clk_i,
    input  wire logic       reset_n_i,
    input  wire logic       play_drq_i,
    input  wire logic       cap_drq_i,
    input  wire logic [3:0] delay_i,
    output logic            play_xfer_o,
    output logic            cap_xfer_o
);
    logic [3:0] wait_reg;

    // one sample per request, capture first, then wait delay_i + 2 cycles before the next
    always_ff @(posedge clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            wait_reg    <= 4'h0;
            play_xfer_o <= 1'h0;
            cap_xfer_o  <= 1'h0;
        end else begin
            play_xfer_o <= 1'h0;
            cap_xfer_o  <= 1'h0;
            if (wait_reg != 4'h0) begin
                wait_reg <= wait_reg - 4'h1;
            end else if (cap_drq_i) begin
                cap_xfer_o <= 1'h1;
                wait_reg   <= delay_i + 4'h2;
            end else if (play_drq_i) begin
                play_xfer_o <= 1'h1;
                wait_reg    <= delay_i + 4'h2;
            end
        end
    end
endmodule : dma_host_model

// ### test/test_codec_count_timer_interrupt.sv
// self-checking bench for the codec control core
`timescale 1ns/1ps
`include "codec_defines.svh"
module test_codec_count_timer_interrupt;
    localparam int TICK = 4;
    logic       clk_i = 1'h0, reset_n_i = 1'h0;
    logic       cs_n_i = 1'h1, rd_n_i = 1'h1, wr_n_i = 1'h1;
    logic       sample_tick_i = 1'h0, play_valid_i = 1'h1;
    logic [1:0] addr_i = 2'h0;
    logic [7:0] data_i = 8'h00, data_o, rv;
    logic       data_oe_o, irq_o, play_drq_o, cap_drq_o;
    logic       play_xfer_i, cap_xfer_i;
    logic [15:0] la[4] = '{16'h0100, 16'h7000, 16'h9000, 16'h0100};
    logic [15:0] lp[4] = '{16'h0200, 16'h7000, 16'h9000, 16'h0000};
    logic [15:0] le[4] = '{16'h0300, 16'h7fff, 16'h8000, 16'h9100};
    codec_pkg::stereo_sample_t adc_i = '0, play_i = '0, dac_o, cap_o;
    int         n_fail = 0, tests_run = 0, cyc = 0, t0;

    codec_count_timer_interrupt #(.TICK_CYC(TICK)) uut (.clk_i, .reset_n_i,
        .cs_n_i, .rd_n_i, .wr_n_i, .addr_i, .data_i, .data_o, .data_oe_o,
        .irq_o, .sample_tick_i, .adc_i, .play_i, .play_valid_i, .play_xfer_i,
        .cap_xfer_i, .dac_o, .cap_o, .play_drq_o, .cap_drq_o);
    dma_host_model dma (.clk_i, .reset_n_i, .play_drq_i(play_drq_o),
        .cap_drq_i(cap_drq_o), .delay_i(4'h1), .play_xfer_o(play_xfer_i),
        .cap_xfer_o(cap_xfer_i));

    initial forever #50 clk_i = ~clk_i;
    always @(posedge clk_i) cyc <= cyc + 1;

    // ************************************************
    // bus cycles and checks
    // ************************************************
    task automatic print_verdict;
        if (n_fail == 0 && tests_run > 0) $display("*** PASS ***");
        else $display("*** FAIL ***");
        $finish;
    endtask : print_verdict
    task automatic cmp(string what, logic [31:0] exp, logic [31:0] got);
        tests_run++;
        if (got !== exp) begin
            n_fail++;
            $display("Error %s expected %h seen %h", what, exp, got);
        end
    endtask : cmp
    task automatic bus(logic [1:0] a, logic wr, logic [7:0] d);
        @(posedge clk_i);
        addr_i <= a;
        data_i <= d;
        cs_n_i <= 1'h0;
        if (wr) wr_n_i <= 1'h0;
        else rd_n_i <= 1'h0;
        repeat (4) @(posedge clk_i);
        rv = data_o;
        cs_n_i <= 1'h1;
        wr_n_i <= 1'h1;
        rd_n_i <= 1'h1;
        repeat (4) @(posedge clk_i);
    endtask : bus
    task automatic wi(logic [4:0] ix, logic [7:0] d);
        bus(2'h0, 1'h1, {3'h0, ix});
        bus(2'h1, 1'h1, d);
    endtask : wi
    task automatic ri(logic [4:0] ix, logic [7:0] m, logic [7:0] e, string s);
        bus(2'h0, 1'h1, {3'h0, ix});
        bus(2'h1, 1'h0, 8'h00);
        cmp(s, {24'h0, e}, {24'h0, rv & m});
    endtask : ri
    task automatic tick(codec_pkg::stereo_sample_t a);
        @(posedge clk_i);
        adc_i <= a;
        sample_tick_i <= 1'h1;
        @(posedge clk_i);
        sample_tick_i <= 1'h0;
        repeat (8) @(posedge clk_i);
    endtask : tick
    task automatic wait_irq;
        int n;
        for (n = 0; n < 400 && irq_o !== 1'h1; n++) @(negedge clk_i);
        if (n == 400) begin
            cmp("irq wait", 32'h1, 32'h0);
            print_verdict();
        end
    endtask : wait_irq

    initial begin
        repeat (100000) @(posedge clk_i);
        cmp("run time", 32'h0, 32'h1);
        print_verdict();
    end

    // ************************************************
    // main sequence
    // ************************************************
    initial begin
        repeat (12) @(posedge clk_i);
        reset_n_i <= 1'h1;
        bus(2'h0, 1'h0, 8'h00);
        cmp("index reset", 32'h40, {24'h0, rv});
        bus(2'h3, 1'h1, 8'h5a);
        bus(2'h3, 1'h0, 8'h00);
        cmp("pio data", 32'h5a, {24'h0, rv});
        wi(5'h18, 8'h10);
        ri(`IX_PLAY_FMT, 8'hff, 8'h10, "legacy alias");
        wi(`IX_MODE_ID, 8'h40);
        wi(`IX_TIMER_HIGH, 8'h00);
        wi(`IX_TIMER_LOW, 8'h10);
        wi(`IX_ALT_EN1, 8'h40);
        repeat (100) @(posedge clk_i);
        bus(2'h2, 1'h0, 8'h00);
        cmp("int bit", 32'h1, {31'h0, rv[0]});
        cmp("masked pin", 32'h0, {31'h0, irq_o});
        ri(`IX_ALT_STATUS, 8'h40, 8'h40, "timer flag");
        wi(`IX_PIN_CTRL, 8'h02);
        cmp("irq pin", 32'h1, {31'h0, irq_o});
        wi(`IX_ALT_EN1, 8'h00);
        bus(2'h2, 1'h1, 8'h00);
        cmp("status clear", 32'h0, {31'h0, irq_o});
        repeat (200) @(posedge clk_i);
        cmp("timer halted", 32'h0, {31'h0, irq_o});
        wi(`IX_ALT_EN1, 8'h40);
        wait_irq();
        t0 = cyc;
        wi(`IX_ALT_STATUS, 8'h00);
        cmp("flag zero write", 32'h0, {31'h0, irq_o});
        wait_irq();
        cmp("timer period", 32'((16 + 1) * TICK), 32'(cyc - t0));
        wi(`IX_ALT_EN1, 8'h00);
        bus(2'h2, 1'h1, 8'h00);
        wi(`IX_CAP_LOWER, 8'h01);
        wi(`IX_CAP_UPPER, 8'h00);
        repeat (2) tick(32'h11112222);
        ri(`IX_ALT_STATUS, 8'h20, 8'h20, "capture flag");
        cmp("capture irq", 32'h1, {31'h0, irq_o});
        wi(`IX_ALT_STATUS, 8'h00);
        cmp("capture clear", 32'h0, {31'h0, irq_o});
        bus(2'h0, 1'h1, 8'h20);
        repeat (2) tick(32'h0);
        tick(32'h0000aaaa);
        tick(32'h0000bbbb);
        cmp("overrun hold", 32'h0000aaaa, cap_o);
        cmp("request masked", 32'h0, {31'h0, cap_drq_o});
        bus(2'h2, 1'h1, 8'h00);
        wi(`IX_IFACE_CFG, 8'h04);
        repeat (3) tick(32'h0);
        ri(`IX_ALT_STATUS, 8'h20, 8'h00, "capture inert");
        ri(`IX_ALT_STATUS, 8'h10, 8'h10, "shared count");
        wi(`IX_LOOPBACK, 8'h01);
        for (int i = 0; i < 4; i++) begin
            play_i <= {lp[i], lp[i]};
            play_valid_i <= (i < 3);
            tick({la[i], la[i]});
            cmp("dac mix", {le[i], le[i]}, dac_o);
        end
        wi(`IX_PIN_CTRL, 8'h42);
        wi(`IX_LOOPBACK, 8'h05);
        tick(32'h02000200);
        cmp("dac zero", 32'h01000100, dac_o);
        tick(32'h02000600);
        cmp("mono mix", 32'h01000100, dac_o);
        wi(`IX_CAP_FMT, 8'h10);
        tick(32'h02000600);
        cmp("stereo mix", 32'h01000300, dac_o);
        cmp("play request", 32'h1, {31'h0, play_drq_o});
        bus(2'h0, 1'h1, 8'h20);
        cmp("play masked", 32'h0, {31'h0, play_drq_o});
        print_verdict();
    end
endmodule : test_codec_count_timer_interrupt
